// ===== design/wav_offset_cfg.sv
`timescale 1ns/10ps
`default_nettype none
module wav_offset_cfg
  import wav_pkg::*;
#(
  parameter int unsigned PEAK_STEP_CYCLES = WAV_PEAK_STEP_CYCLES,
  parameter int unsigned STEP_PERIOD_MS = WAV_STEP_PERIOD_MS
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic seg_in_valid,
  input wire wav_seg_t seg_in,
  input wire logic signed [7:0] wave_max_amp,
  input wire logic signed [7:0] wave_min_amp,
  input wire logic closed_loop,
  output logic seg_out_valid,
  output wav_seg_res_t seg_out,
  input wire logic av_sample_valid,
  input wire logic [7:0] av_sample,
  output logic [7:0] av_level,
  output logic av_peak_valid,
  output logic [7:0] av_peak,
  output logic [7:0] av_lowpass_hz
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // word hit for a mapped register
  function automatic logic reg_hit(logic [7:0] a);
    logic [5:0] i;
    i = a[7:2];
    return (a[1:0] == 2'h0) && (i >= WAV_IDX_POS_SUSTAIN) && (i <= WAV_IDX_AV_FULL_SCALE);
  endfunction

  // step count plus signed offset, held within 0..255
  function automatic logic [7:0] sat_add(logic [7:0] s, logic [7:0] o);
    logic signed [9:0] t;
    t = $signed({2'b00, s}) + $signed({{2{o[7]}}, o});
    if (t < 0) return 8'h00;
    if (t > 10'sd255) return 8'hFF;
    return t[7:0];
  endfunction

  // offset in milliseconds
  function automatic logic signed [15:0] to_ms(logic [7:0] o);
    return $signed({{8{o[7]}}, o}) * $signed(16'(STEP_PERIOD_MS));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [7:0] pos_reg, pos_next, neg_reg, neg_next, brk_reg, brk_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [7:0] floor_reg, floor_next, full_reg, full_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] rdata_reg, rdata_next;
  logic aw_take, w_take, do_wr;
  logic [7:0] wa;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};

  // address and data taken in either order, answered once both are in
  always_comb
  begin
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    aw_got_next = aw_got_reg || aw_take;
    w_got_next = w_got_reg || w_take;
    awaddr_next = aw_take ? s_axi_awaddr : awaddr_reg;
    wdata_next = w_take ? s_axi_wdata[7:0] : wdata_reg;
    wstrb_next = w_take ? s_axi_wstrb[0] : wstrb_reg;
    do_wr = aw_got_next && w_got_next;
    wa = awaddr_next;
    pos_next = pos_reg;
    neg_next = neg_reg;
    brk_next = brk_reg;
    ctrl_next = ctrl_reg;
    floor_next = floor_reg;
    full_next = full_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    if (do_wr)
    begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = reg_hit(wa) ? WAV_RESP_OKAY : WAV_RESP_SLVERR;
      if (reg_hit(wa) && wstrb_next)
      begin
        unique case (wa[7:2])
          WAV_IDX_POS_SUSTAIN: pos_next = wdata_next;
          WAV_IDX_NEG_SUSTAIN: neg_next = wdata_next;
          WAV_IDX_BRAKE: brk_next = wdata_next;
          WAV_IDX_AV_CONTROL: ctrl_next = wdata_next[3:0];
          WAV_IDX_AV_FLOOR: floor_next = wdata_next;
          default: full_next = wdata_next;
        endcase
      end
    end
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = reg_hit(s_axi_araddr) ? WAV_RESP_OKAY : WAV_RESP_SLVERR;
      rdata_next = 8'h00;
      if (reg_hit(s_axi_araddr))
      begin
        unique case (s_axi_araddr[7:2])
          WAV_IDX_POS_SUSTAIN: rdata_next = pos_reg;
          WAV_IDX_NEG_SUSTAIN: rdata_next = neg_reg;
          WAV_IDX_BRAKE: rdata_next = brk_reg;
          WAV_IDX_AV_CONTROL: rdata_next = {4'h0, ctrl_reg};
          WAV_IDX_AV_FLOOR: rdata_next = floor_reg;
          default: rdata_next = full_reg;
        endcase
      end
    end
  end

  // bus and register state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_reg <= WAV_RST_OFFSET;
      neg_reg <= WAV_RST_OFFSET;
      brk_reg <= WAV_RST_OFFSET;
      ctrl_reg <= WAV_RST_AV_CONTROL;
      floor_reg <= WAV_RST_AV_FLOOR;
      full_reg <= WAV_RST_AV_FULL_SCALE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= WAV_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= WAV_RESP_OKAY;
      rdata_reg <= 8'h00;
    end
    else
    begin
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      brk_reg <= brk_next;
      ctrl_reg <= ctrl_next;
      floor_reg <= floor_next;
      full_reg <= full_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // segment classification and time adjustment

  logic seg_valid_reg, seg_valid_next;
  wav_seg_res_t seg_reg, seg_next;

  assign seg_out_valid = seg_valid_reg;
  assign seg_out = seg_reg;

  // overdrive wins over sustain; brake wins over negative sustain
  always_comb
  begin
    seg_valid_next = seg_in_valid;
    seg_next = seg_reg;
    if (seg_in_valid)
    begin
      seg_next.steps = seg_in.steps;
      seg_next.adj_ms = 16'sh0000;
      if (seg_in.amp > 0 && seg_in.amp == wave_max_amp)
        seg_next.cls = WAV_SEG_OVERDRIVE;
      else if (seg_in.amp > 0)
      begin
        seg_next.cls = WAV_SEG_POS;
        seg_next.steps = sat_add(seg_in.steps, pos_reg);
        seg_next.adj_ms = to_ms(pos_reg);
      end
      else if (seg_in.amp < 0 && seg_in.amp == wave_min_amp)
      begin
        seg_next.cls = WAV_SEG_BRAKE;
        if (!closed_loop)
        begin
          seg_next.steps = sat_add(seg_in.steps, brk_reg);
          seg_next.adj_ms = to_ms(brk_reg);
        end
      end
      else if (seg_in.amp < 0)
      begin
        seg_next.cls = WAV_SEG_NEG;
        seg_next.steps = sat_add(seg_in.steps, neg_reg);
        seg_next.adj_ms = to_ms(neg_reg);
      end
      else
        seg_next.cls = WAV_SEG_NONE;
    end
  end

  // segment result registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seg_valid_reg <= 1'b0;
      seg_reg <= '{cls: WAV_SEG_NONE, steps: 8'h00, adj_ms: 16'sh0000};
    end
    else
    begin
      seg_valid_reg <= seg_valid_next;
      seg_reg <= seg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // audio-to-vibration level, peak window, filter corner

  logic [7:0] level_reg, level_next, peak_reg, peak_next, pkmax_reg, pkmax_next;
  logic peak_valid_reg, peak_valid_next;
  logic [23:0] pcnt_reg, pcnt_next, peak_limit;
  logic [1:0] peak_code, filt_code;

  assign peak_code = ctrl_reg[WAV_PEAK_LSB +: 2];
  assign filt_code = ctrl_reg[WAV_FILTER_LSB +: 2];
  assign peak_limit = 24'(({22'h000000, peak_code} + 24'h000001)
    * 24'(PEAK_STEP_CYCLES)) - 24'h000001;
  assign av_level = level_reg;
  assign av_peak = peak_reg;
  assign av_peak_valid = peak_valid_reg;

  // corner frequency per code
  always_comb
  begin
    unique case (filt_code)
      2'h0: av_lowpass_hz = WAV_LPF_HZ0;
      2'h1: av_lowpass_hz = WAV_LPF_HZ1;
      2'h2: av_lowpass_hz = WAV_LPF_HZ2;
      default: av_lowpass_hz = WAV_LPF_HZ3;
    endcase
  end

  // floor gate, full-scale cap, windowed peak hold
  always_comb
  begin
    level_next = level_reg;
    if (av_sample_valid)
    begin
      if (av_sample < floor_reg)
        level_next = 8'h00;
      else if (av_sample > full_reg)
        level_next = full_reg;
      else
        level_next = av_sample;
    end
    pkmax_next = (av_sample_valid && level_next > pkmax_reg) ? level_next : pkmax_reg;
    peak_valid_next = 1'b0;
    peak_next = peak_reg;
    pcnt_next = pcnt_reg + 24'h000001;
    if (pcnt_reg >= peak_limit)
    begin
      pcnt_next = 24'h000000;
      peak_valid_next = 1'b1;
      peak_next = pkmax_next;
      pkmax_next = 8'h00;
    end
  end

  // audio path registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg <= 8'h00;
      peak_reg <= 8'h00;
      pkmax_reg <= 8'h00;
      peak_valid_reg <= 1'b0;
      pcnt_reg <= 24'h000000;
    end
    else
    begin
      level_reg <= level_next;
      peak_reg <= peak_next;
      pkmax_reg <= pkmax_next;
      peak_valid_reg <= peak_valid_next;
      pcnt_reg <= pcnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_pos_seg;
    seg_in_valid && seg_in.amp > 0 && seg_in.amp != wave_max_amp;
  endsequence
  sequence s_neg_seg;
    seg_in_valid && seg_in.amp < 0 && seg_in.amp != wave_min_amp;
  endsequence
  sequence s_brk_seg;
    seg_in_valid && seg_in.amp < 0 && seg_in.amp == wave_min_amp;
  endsequence

  a_pos_sustain_class: assert property (s_pos_seg |=> seg_out.cls == WAV_SEG_POS)
    else $error("positive segment misclassified");
  a_pos_sustain_steps: assert property (s_pos_seg |=>
    seg_out.steps == sat_add($past(seg_in.steps), $past(pos_reg)))
    else $error("positive sustain steps wrong");
  a_pos_sustain_ms: assert property (s_pos_seg |=>
    seg_out.adj_ms == $signed($past(pos_reg)) * $signed(16'(STEP_PERIOD_MS)))
    else $error("positive sustain ms wrong");
  a_neg_sustain_steps: assert property (s_neg_seg |=>
    seg_out.cls == WAV_SEG_NEG && seg_out.steps == sat_add($past(seg_in.steps), $past(neg_reg)))
    else $error("negative sustain wrong");
  a_neg_sustain_ms: assert property (s_neg_seg |=> seg_out.adj_ms == to_ms($past(neg_reg)))
    else $error("negative sustain ms wrong");
  a_brake_open_loop: assert property (s_brk_seg and !closed_loop |=>
    seg_out.cls == WAV_SEG_BRAKE && seg_out.steps == sat_add($past(seg_in.steps), $past(brk_reg)))
    else $error("open loop brake wrong");
  a_brake_closed_loop: assert property (s_brk_seg and closed_loop |=>
    seg_out.steps == $past(seg_in.steps) && seg_out.adj_ms == 16'sh0000)
    else $error("closed loop brake adjusted");
  a_overdrive_kept: assert property (seg_in_valid && seg_in.amp > 0 &&
    seg_in.amp == wave_max_amp |=> seg_out.cls == WAV_SEG_OVERDRIVE
    && seg_out.steps == $past(seg_in.steps))
    else $error("overdrive misclassified");
  a_peak_window_len: assert property (av_peak_valid |->
    (pcnt_reg == 24'h000000) && !$past(av_peak_valid))
    else $error("peak window spacing wrong");
  a_lowpass_code: assert property (filt_code == 2'h1 |-> av_lowpass_hz == 8'h7D)
    else $error("low-pass corner wrong");
  a_floor_ignore: assert property (av_sample_valid && av_sample < floor_reg |=>
    av_level == 8'h00)
    else $error("level below floor passed");
  a_full_scale_cap: assert property (av_sample_valid |=> av_level <= $past(full_reg))
    else $error("level above full scale");
  a_ctrl_reserved: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == {WAV_IDX_AV_CONTROL, 2'h0} |=> s_axi_rdata[31:4] == 28'h0000000)
    else $error("reserved control bits not zero");

endmodule
`default_nettype wire

// ===== design/wav_pkg.sv
`default_nettype none
package wav_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] WAV_IDX_POS_SUSTAIN = 6'h0E;
  localparam logic [5:0] WAV_IDX_NEG_SUSTAIN = 6'h0F;
  localparam logic [5:0] WAV_IDX_BRAKE = 6'h10;
  localparam logic [5:0] WAV_IDX_AV_CONTROL = 6'h11;
  localparam logic [5:0] WAV_IDX_AV_FLOOR = 6'h12;
  localparam logic [5:0] WAV_IDX_AV_FULL_SCALE = 6'h13;
  // reset values
  localparam logic [7:0] WAV_RST_OFFSET = 8'h00;
  localparam logic [3:0] WAV_RST_AV_CONTROL = 4'h5;
  localparam logic [7:0] WAV_RST_AV_FLOOR = 8'h19;
  localparam logic [7:0] WAV_RST_AV_FULL_SCALE = 8'hFF;
  // control field positions
  localparam int WAV_PEAK_LSB = 2;
  localparam int WAV_FILTER_LSB = 0;
  // timing
  localparam int unsigned WAV_CLK_HZ = 20000000;
  localparam int unsigned WAV_PEAK_STEP_MS = 10;
  localparam int unsigned WAV_PEAK_STEP_CYCLES = WAV_PEAK_STEP_MS * (WAV_CLK_HZ / 1000);
  localparam int unsigned WAV_STEP_PERIOD_MS = 5;
  // low-pass corner per code, in hertz
  localparam logic [7:0] WAV_LPF_HZ0 = 8'h64;
  localparam logic [7:0] WAV_LPF_HZ1 = 8'h7D;
  localparam logic [7:0] WAV_LPF_HZ2 = 8'h96;
  localparam logic [7:0] WAV_LPF_HZ3 = 8'hC8;
  // bus answers
  localparam logic [1:0] WAV_RESP_OKAY = 2'h0;
  localparam logic [1:0] WAV_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WAV_SEG_NONE,
    WAV_SEG_OVERDRIVE,
    WAV_SEG_POS,
    WAV_SEG_NEG,
    WAV_SEG_BRAKE
  } wav_seg_class_t;

  typedef struct packed {
    logic signed [7:0] amp;
    logic [7:0] steps;
  } wav_seg_t;

  typedef struct packed {
    wav_seg_class_t cls;
    logic [7:0] steps;
    logic signed [15:0] adj_ms;
  } wav_seg_res_t;
endpackage
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import wav_pkg::*;
  localparam int unsigned PEAK = 8;
  localparam int unsigned STEP = 5;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic seg_in_valid = 1'b0, closed_loop = 1'b0, av_sample_valid = 1'b0;
  wav_seg_t seg_in = '0;
  logic signed [7:0] wave_max_amp = 8'sh64, wave_min_amp = -8'sh64;
  logic seg_out_valid, av_peak_valid;
  wav_seg_res_t seg_out;
  logic [7:0] av_sample = 8'h00;
  logic [7:0] av_level, av_peak, av_lowpass_hz;
  int fail_count = 0;
  int samples_checked = 0;
  int n;

  wav_offset_cfg #(.PEAK_STEP_CYCLES(PEAK), .STEP_PERIOD_MS(STEP)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .seg_in_valid(seg_in_valid), .seg_in(seg_in), .wave_max_amp(wave_max_amp),
    .wave_min_amp(wave_min_amp), .closed_loop(closed_loop), .seg_out_valid(seg_out_valid),
    .seg_out(seg_out), .av_sample_valid(av_sample_valid), .av_sample(av_sample),
    .av_level(av_level), .av_peak_valid(av_peak_valid), .av_peak(av_peak),
    .av_lowpass_hz(av_lowpass_hz)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus write of one register word by index
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // bus read of one register word by index
  task automatic rdr(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // read and compare data and response
  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
    rdr(idx, rd, resp);
    chk("read data", {24'h0, exp}, rd);
    chk("read resp", {30'h0, er}, {30'h0, resp});
  endtask

  // one segment in, classified result one cycle later
  task automatic seg(input logic signed [7:0] amp, input logic [7:0] st,
                     input wav_seg_class_t c, input logic [7:0] es, input int ea);
    @(posedge sys_clk);
    seg_in_valid <= 1'b1;
    seg_in <= '{amp: amp, steps: st};
    @(posedge sys_clk);
    seg_in_valid <= 1'b0;
    #1;
    chk("seg valid", 32'h1, {31'h0, seg_out_valid});
    chk("seg class", {29'h0, c}, {29'h0, seg_out.cls});
    chk("seg steps", {24'h0, es}, {24'h0, seg_out.steps});
    chk("seg adj", {16'h0, 16'(ea)}, {16'h0, seg_out.adj_ms});
  endtask

  // one audio sample in, gated level one cycle later
  task automatic aud(input logic [7:0] s, input logic [7:0] exp);
    @(posedge sys_clk);
    av_sample_valid <= 1'b1;
    av_sample <= s;
    @(posedge sys_clk);
    av_sample_valid <= 1'b0;
    #1;
    chk("audio level", {24'h0, exp}, {24'h0, av_level});
  endtask

  // cycles until the next peak pulse
  task automatic next_peak(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end while (!av_peak_valid && cyc < 400);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    #(20000 * 50);
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and unmapped place
    rchk(WAV_IDX_POS_SUSTAIN, 8'h00, WAV_RESP_OKAY);
    rchk(WAV_IDX_NEG_SUSTAIN, 8'h00, WAV_RESP_OKAY);
    rchk(WAV_IDX_BRAKE, 8'h00, WAV_RESP_OKAY);
    rchk(WAV_IDX_AV_CONTROL, 8'h05, WAV_RESP_OKAY);
    rchk(WAV_IDX_AV_FLOOR, 8'h19, WAV_RESP_OKAY);
    rchk(WAV_IDX_AV_FULL_SCALE, 8'hFF, WAV_RESP_OKAY);
    chk("lowpass reset", 32'h7D, {24'h0, av_lowpass_hz});
    rchk(6'h00, 8'h00, WAV_RESP_SLVERR);
    wr(6'h00, 8'hAA, resp);
    chk("unmapped write resp", {30'h0, WAV_RESP_SLVERR}, {30'h0, resp});
    // reserved control bits
    wr(WAV_IDX_AV_CONTROL, 8'hFF, resp);
    chk("control write resp", {30'h0, WAV_RESP_OKAY}, {30'h0, resp});
    rchk(WAV_IDX_AV_CONTROL, 8'h0F, WAV_RESP_OKAY);
    $display("test registers done");
    // segment offsets, classes and saturation
    wr(WAV_IDX_POS_SUSTAIN, 8'h02, resp);
    wr(WAV_IDX_NEG_SUSTAIN, 8'hFE, resp);
    wr(WAV_IDX_BRAKE, 8'h03, resp);
    // low strobe clear: answered but not stored
    wstrb <= 4'h0;
    wr(WAV_IDX_BRAKE, 8'h55, resp);
    chk("masked write resp", {30'h0, WAV_RESP_OKAY}, {30'h0, resp});
    wstrb <= 4'hF;
    rchk(WAV_IDX_BRAKE, 8'h03, WAV_RESP_OKAY);
    rchk(WAV_IDX_NEG_SUSTAIN, 8'hFE, WAV_RESP_OKAY);
    seg(8'sh64, 8'h0A, WAV_SEG_OVERDRIVE, 8'h0A, 0);
    seg(8'sh32, 8'h0A, WAV_SEG_POS, 8'h0C, 2 * STEP);
    seg(8'sh32, 8'hFF, WAV_SEG_POS, 8'hFF, 2 * STEP);
    seg(-8'sh14, 8'h0A, WAV_SEG_NEG, 8'h08, -2 * STEP);
    seg(-8'sh14, 8'h01, WAV_SEG_NEG, 8'h00, -2 * STEP);
    seg(-8'sh64, 8'h0A, WAV_SEG_BRAKE, 8'h0D, 3 * STEP);
    // level inputs change only at a rising edge
    @(posedge sys_clk);
    closed_loop <= 1'b1;
    seg(-8'sh64, 8'h0A, WAV_SEG_BRAKE, 8'h0A, 0);
    @(posedge sys_clk);
    closed_loop <= 1'b0;
    seg(8'sh00, 8'h0A, WAV_SEG_NONE, 8'h0A, 0);
    @(posedge sys_clk);
    wave_max_amp <= 8'sh32;
    seg(8'sh32, 8'h05, WAV_SEG_OVERDRIVE, 8'h05, 0);
    $display("test segments done");
    // audio floor and full scale
    aud(8'h10, 8'h00);
    aud(8'h19, 8'h19);
    wr(WAV_IDX_AV_FULL_SCALE, 8'h80, resp);
    aud(8'hA0, 8'h80);
    wr(WAV_IDX_AV_FLOOR, 8'h40, resp);
    aud(8'h3F, 8'h00);
    aud(8'h50, 8'h50);
    $display("test audio done");
    // peak window and low-pass corner for every code
    // a steady sample stream, so every window holds a peak
    @(posedge sys_clk);
    av_sample_valid <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(WAV_IDX_AV_CONTROL, 8'(c * 5), resp);
      #1;
      chk("lowpass", (c == 0) ? 32'h64 : (c == 1) ? 32'h7D : (c == 2) ? 32'h96 : 32'hC8,
          {24'h0, av_lowpass_hz});
      @(posedge sys_clk);
      av_sample <= 8'h48 + 8'(c);
      next_peak(n);
      next_peak(n);
      chk("peak window", 32'((c + 1) * PEAK), 32'(n));
      chk("peak value", 32'h48 + 32'(c), {24'h0, av_peak});
    end
    $display("test peak window done");
    report_and_stop();
  end
endmodule
`default_nettype wire
